// ===== tb/rale_encoder_tb.sv
// self-checking bench for the lamp and alarm encoder
// assumes the shelf model resolves the open-drain alarm lines
`timescale 1ns/100ps
`include "rale_defs.svh"
module rale_encoder_tb import rale_pkg::*;;
	localparam logic [1:0] N = 2'b10, F = 2'b01, B = 2'b11;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic pready, pslverr, err, l_in, l_out, l_svc, l_red;
	logic [13:0] cond_pins = 0;
	logic unit_installed = 1, fault_n, fault_oe, otw_n, otw_oe;
	logic power_fail, power_fail_oe;
	logic flag, bus_alarm, irq, fault_line, otw_line, power_fail_line;
	int failures = 0, n_tests = 0;
	always #5 pclk = ~pclk;
	rale_encoder #(.BLINK_CYC(4)) uut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .cond_pins(cond_pins),
		.unit_installed(unit_installed), .lamp_input(l_in),
		.lamp_output(l_out), .lamp_service(l_svc), .lamp_fault(l_red),
		.fault_n(fault_n), .fault_oe(fault_oe),
		.overtemp_warning_n(otw_n), .overtemp_warning_oe(otw_oe),
		.power_fail_warning(power_fail),
		.power_fail_warning_oe(power_fail_oe),
		.unit_inserted_flag(flag), .bus_alarm(bus_alarm), .irq(irq));
	rale_shelf_model shelf (.fault_oe(fault_oe), .otw_oe(otw_oe),
		.power_fail_oe(power_fail_oe), .fault_line(fault_line),
		.otw_line(otw_line), .power_fail_line(power_fail_line));
	task stop_test;
		$display("checks %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task check(input string nm, input logic [31:0] seen, exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		for (i = 0; i < 20; i++) begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		if (i == 20) begin
			failures++;
			stop_test();
		end
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	// watch 16 cycles: a 4-cycle blink half period shows both levels
	task run_case(input logic [13:0] c, input logic [1:0] m,
			input logic [7:0] lk, input logic [2:0] al);
		logic [3:0] hi, lo;
		logic [7:0] s;
		hi = 0;
		lo = 0;
		apb(1, `RALE_OFF_MODE, {30'h0, m});
		apb(1, `RALE_OFF_COND, {18'h0, c});
		repeat (3) @(negedge pclk);
		repeat (16) begin
			@(negedge pclk);
			hi = hi | {l_in, l_out, l_svc, l_red};
			lo = lo | ~{l_in, l_out, l_svc, l_red};
		end
		for (int i = 0; i < 4; i++)
			s[2*i +: 2] = {hi[i], lo[i]};
		check("lamps", s, lk);
		check("alarm lines", {fault_line, otw_line, power_fail_line}, al);
		check("bus_alarm", bus_alarm, !al[2]);
	endtask
	task test_regs;
		apb(0, `RALE_OFF_MODE, 0);
		check("mode reset", rd, 0);
		apb(0, 12'h020, 0);
		check("unmapped err", err, 1);
		apb(1, `RALE_OFF_MODE, 1);
		apb(1, `RALE_OFF_MODE, 3);
		apb(0, `RALE_OFF_MODE, 0);
		check("mode kept", rd, 1);
		$display("done regs");
	endtask
	task test_lamps;
		run_case(14'h0001, 0, {N, N, F, F}, 3'b111);
		run_case(14'h0005, 0, {N, N, N, F}, 3'b101);
		run_case(14'h2009, 0, {N, F, N, N}, 3'b000);
		run_case(14'h2011, 0, {N, F, F, N}, 3'b010);
		run_case(14'h2021, 0, {N, F, F, N}, 3'b010);
		run_case(14'h2041, 0, {N, F, F, N}, 3'b010);
		run_case(14'h2081, 0, {N, F, F, N}, 3'b010);
		run_case(14'h0002, 0, {B, F, F, F}, 3'b111);
		run_case(14'h2002, 0, {B, F, F, F}, 3'b110);
		run_case(14'h2000, 0, {F, F, F, F}, 3'b110);
		run_case(14'h2101, 0, {N, B, F, F}, 3'b110);
		run_case(14'h2201, 0, {N, F, F, F}, 3'b110);
		run_case(14'h0401, 0, {N, N, F, N}, 3'b011);
		run_case(14'h0801, 1, {N, N, B, F}, 3'b111);
		run_case(14'h1001, 2, {N, N, F, B}, 3'b111);
		$display("done lamps");
	endtask
	task test_irq;
		apb(1, `RALE_OFF_COND, 1);
		apb(1, `RALE_OFF_STAT, 32'hf);
		apb(1, `RALE_OFF_MASK, 32'h5);
		@(negedge pclk);
		check("irq idle", irq, 0);
		apb(1, `RALE_OFF_COND, 32'h2009);
		repeat (3) @(negedge pclk);
		check("irq alarms fell", irq, 1);
		apb(1, `RALE_OFF_MASK, 0);
		@(negedge pclk);
		check("irq masked", irq, 0);
		apb(1, `RALE_OFF_MASK, 32'h4);
		@(negedge pclk);
		check("irq unmasked", irq, 1);
		apb(1, `RALE_OFF_STAT, 32'h4);
		@(negedge pclk);
		check("irq cleared", irq, 0);
		apb(0, `RALE_OFF_STAT, 0);
		check("status bits", rd, 32'h3);
		$display("done irq");
	endtask
	// reset in mid-run: outputs fall back to their idle levels at once
	task test_reset;
		@(posedge pclk);
		presetn <= 0;
		@(negedge pclk);
		check("reset lamps", {l_in, l_out, l_svc, l_red}, 0);
		check("reset alarms", {fault_line, otw_line, power_fail_line, flag,
			irq}, 5'b11110);
		@(posedge pclk);
		presetn <= 1;
		apb(0, `RALE_OFF_MODE, 0);
		check("reset mode", rd, 0);
		$display("done reset");
	endtask
	task test_pins;
		apb(1, `RALE_OFF_COND, 0);
		@(posedge pclk);
		cond_pins <= 14'h0005;
		repeat (5) @(negedge pclk);
		check("pin otw", {otw_line, l_svc}, 2'b01);
		@(posedge pclk);
		unit_installed <= 0;
		repeat (5) @(negedge pclk);
		check("missing", flag, 1);
		apb(0, `RALE_OFF_STAT, 0);
		check("presence event", rd[3], 1);
		@(posedge pclk);
		unit_installed <= 1;
		repeat (5) @(negedge pclk);
		check("installed", flag, 0);
		$display("done pins");
	endtask
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1;
		test_regs();
		test_lamps();
		test_irq();
		test_pins();
		test_reset();
		stop_test();
	end
endmodule

// ===== tb/rale_shelf_model.sv
// shelf controller side: open-drain alarm lines with pull-ups
// assumes oe high means the encoder sinks the line
`timescale 1ns/100ps
module rale_shelf_model (
	input wire logic fault_oe,
	input wire logic otw_oe,
	input wire logic power_fail_oe,
	output logic fault_line,
	output logic otw_line,
	output logic power_fail_line
);
	// pull-up wins whenever nobody sinks the line
	assign fault_line = fault_oe ? 1'b0 : 1'b1;
	assign otw_line = otw_oe ? 1'b0 : 1'b1;
	assign power_fail_line = power_fail_oe ? 1'b0 : 1'b1;
endmodule

// ===== verilog/rale_defs.svh
// constants for the lamp and alarm encoder: offsets, fields, timings
// assumes pclk at 100 MHz and an APB master in front of the block
//
// Behaviour
// RULE1 - warn: amber on, warning low; shutdown: output dark, red, all low
// RULE2 - input out of limits: input blinks, rest dark, fault, warning high
// RULE3 - internal shutdown: input, red lit; fault and power-fail low
// RULE4 - non-shutdown internal fault: input, output, red lit, fault low
// RULE5 - service request in two-wire mode blinks amber, alarms high
// RULE6 - comms fault in serial-link mode blinks red, alarms high
// RULE7 - input absent: all lamps dark, power-fail low, others high
// RULE8 - power-fail follows boost decay, not input regulation window
// RULE9 - overcurrent blinks output, standby darkens it; power-fail low
// RULE10 - normal: input, output lamps only; presence low when installed
// RULE11 - external faults never light red, drive fault or raise bus alarm
// RULE12 - power-fail goes low about 5 ms before output decays
`ifndef RALE_DEFS_SVH
`define RALE_DEFS_SVH

`define RALE_CLK_HZ 100000000
`define RALE_BLINK_MS 250
`define RALE_BLINK_CYC ((`RALE_CLK_HZ / 1000) * `RALE_BLINK_MS)

`define RALE_OFF_COND 12'h000
`define RALE_OFF_MODE 12'h004
`define RALE_OFF_LAMP 12'h008
`define RALE_OFF_STAT 12'h00c
`define RALE_OFF_MASK 12'h010

// condition bit positions
`define RALE_C_INPUT_OK 0
`define RALE_C_INPUT_PRESENT 1
`define RALE_C_THERM_WARN 2
`define RALE_C_THERM_SHUT 3
`define RALE_C_FAN 4
`define RALE_C_FUSE 5
`define RALE_C_BOOST 6
`define RALE_C_OVLATCH 7
`define RALE_C_OVERCUR 8
`define RALE_C_STANDBY 9
`define RALE_C_INTFAULT 10
`define RALE_C_SERVICE 11
`define RALE_C_COMMS 12
`define RALE_C_BOOST_LOW 13
`define RALE_COND_W 14

`define RALE_STAT_W 4

`endif

// ===== verilog/rale_encoder.sv
// status lamp and alarm encoder of a power module, registers on APB
// assumes condition flags arrive either by register or by pins from
// monitors in other domains; pins are synchronised here
//
// The register addresses and the APB interface to the registers were left to the implementer.
`timescale 1ns/100ps
`include "rale_defs.svh"
module rale_encoder import rale_pkg::*; #(
	parameter int BLINK_CYC = `RALE_BLINK_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [`RALE_COND_W-1:0] cond_pins,
	input wire logic unit_installed,
	output logic lamp_input,
	output logic lamp_output,
	output logic lamp_service,
	output logic lamp_fault,
	output logic fault_n,
	output logic fault_oe,
	output logic overtemp_warning_n,
	output logic overtemp_warning_oe,
	output logic power_fail_warning,
	output logic power_fail_warning_oe,
	output logic unit_inserted_flag,
	output logic bus_alarm,
	output logic irq
);
	if (BLINK_CYC < 2) begin : gen_blink_check
		$error("BLINK_CYC too small");
	end

	// ****************************************
	// synchronisers
	// ****************************************
	logic [`RALE_COND_W-1:0] cond_meta;
	logic [`RALE_COND_W-1:0] cond_sync;
	logic inst_meta;
	logic inst_sync;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cond_meta <= '0;
			cond_sync <= '0;
			inst_meta <= 1'b0;
			inst_sync <= 1'b0;
		end else begin
			cond_meta <= cond_pins;
			cond_sync <= cond_meta;
			inst_meta <= unit_installed;
			inst_sync <= inst_meta;
		end
	end

	// ****************************************
	// registers
	// ****************************************
	logic [`RALE_COND_W-1:0] cond_force;
	rale_mode_type mode;
	logic [`RALE_STAT_W-1:0] status;
	logic [`RALE_STAT_W-1:0] mask;
	logic wr;
	logic rd;
	logic [`RALE_STAT_W-1:0] events;
	assign wr = psel && penable && pwrite;
	assign rd = psel && penable && !pwrite;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !(paddr == `RALE_OFF_COND
		|| paddr == `RALE_OFF_MODE || paddr == `RALE_OFF_LAMP
		|| paddr == `RALE_OFF_STAT || paddr == `RALE_OFF_MASK);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			cond_force <= '0;
		else if (wr && paddr == `RALE_OFF_COND)
			cond_force <= pwdata[`RALE_COND_W-1:0];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			mode <= RALE_MODE_ANALOG;
		else if (wr && paddr == `RALE_OFF_MODE && pwdata[1:0] != 2'b11)
			mode <= rale_mode_type'(pwdata[1:0]);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			mask <= '0;
		else if (wr && paddr == `RALE_OFF_MASK)
			mask <= pwdata[`RALE_STAT_W-1:0];
	end

	// set wins over a write-one clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			status <= '0;
		else if (wr && paddr == `RALE_OFF_STAT)
			status <= (status & ~pwdata[`RALE_STAT_W-1:0]) | events;
		else
			status <= status | events;
	end
	assign irq = |(status & mask);

	// ****************************************
	// condition decode
	// ****************************************
	logic [`RALE_COND_W-1:0] c;
	assign c = cond_sync | cond_force;
	logic in_ok, in_present, tw, ts, shut_int, ovc, stby, intf, svc;
	logic comms, boost_low;
	assign in_ok = c[`RALE_C_INPUT_OK];
	assign in_present = c[`RALE_C_INPUT_PRESENT] | in_ok;
	assign tw = c[`RALE_C_THERM_WARN];
	assign ts = c[`RALE_C_THERM_SHUT];
	assign shut_int = c[`RALE_C_FAN] | c[`RALE_C_FUSE] | c[`RALE_C_BOOST]
		| c[`RALE_C_OVLATCH];
	assign ovc = c[`RALE_C_OVERCUR];
	assign stby = c[`RALE_C_STANDBY];
	assign intf = c[`RALE_C_INTFAULT];
	assign svc = c[`RALE_C_SERVICE] && mode == RALE_MODE_TWO_WIRE;
	assign comms = c[`RALE_C_COMMS] && mode == RALE_MODE_SERIAL;
	assign boost_low = c[`RALE_C_BOOST_LOW];

	// ****************************************
	// blink divider
	// ****************************************
	logic [31:0] blink_cnt;
	logic blink;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			blink_cnt <= '0;
			blink <= 1'b0;
		end else if (blink_cnt == 32'(BLINK_CYC - 1)) begin
			blink_cnt <= '0;
			blink <= ~blink;
		end else begin
			blink_cnt <= blink_cnt + 32'h1;
		end
	end

	// ****************************************
	// lamp and alarm priority encoder
	// ****************************************
	rale_lamp_type l_in, l_out, l_svc, l_red;
	logic n_fault, n_otw, n_power_fail;
	always_comb begin
		l_in = RALE_LAMP_ON;
		l_out = RALE_LAMP_ON;
		l_svc = RALE_LAMP_OFF;
		l_red = RALE_LAMP_OFF;
		n_fault = 1'b1;
		n_otw = 1'b1;
		// power-fail tracks boost decay, which leads output decay by ~5 ms
		n_power_fail = !boost_low; // RULE8 RULE12
		if (!in_present) begin
			l_in = RALE_LAMP_OFF; // RULE7
			l_out = RALE_LAMP_OFF;
			n_power_fail = 1'b0;
		end else if (ts) begin
			l_out = RALE_LAMP_OFF; // RULE1
			l_svc = RALE_LAMP_ON;
			l_red = RALE_LAMP_ON;
			n_fault = 1'b0;
			n_otw = 1'b0;
			n_power_fail = 1'b0;
		end else if (shut_int) begin
			l_out = RALE_LAMP_OFF; // RULE3
			l_red = RALE_LAMP_ON;
			n_fault = 1'b0;
			n_power_fail = 1'b0;
		end else if (!in_ok) begin
			// external fault: no red, no fault line
			l_in = RALE_LAMP_BLINK; // RULE2 RULE11
			l_out = RALE_LAMP_OFF;
		end else if (tw) begin
			l_svc = RALE_LAMP_ON; // RULE1
			n_otw = 1'b0;
		end else if (ovc) begin
			l_out = RALE_LAMP_BLINK; // RULE9 RULE11
			n_power_fail = 1'b0;
		end else if (stby) begin
			l_out = RALE_LAMP_OFF; // RULE9
			n_power_fail = 1'b0;
		end else if (intf) begin
			l_red = RALE_LAMP_ON; // RULE4
			n_fault = 1'b0;
		end else if (svc) begin
			l_svc = RALE_LAMP_BLINK; // RULE5
		end else if (comms) begin
			l_red = RALE_LAMP_BLINK; // RULE6
		end
	end

	function automatic logic lamp_drive(rale_lamp_type s, logic b);
		return (s == RALE_LAMP_ON) || (s == RALE_LAMP_BLINK && b);
	endfunction

	// RULE10: normal state falls through the encoder defaults
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lamp_input <= 1'b0;
			lamp_output <= 1'b0;
			lamp_service <= 1'b0;
			lamp_fault <= 1'b0;
			fault_n <= 1'b1;
			overtemp_warning_n <= 1'b1;
			power_fail_warning <= 1'b1;
			unit_inserted_flag <= 1'b1;
			bus_alarm <= 1'b0;
		end else begin
			lamp_input <= lamp_drive(l_in, blink);
			lamp_output <= lamp_drive(l_out, blink);
			lamp_service <= lamp_drive(l_svc, blink);
			lamp_fault <= lamp_drive(l_red, blink);
			fault_n <= n_fault;
			overtemp_warning_n <= n_otw;
			power_fail_warning <= n_power_fail;
			unit_inserted_flag <= !inst_sync; // RULE10
			bus_alarm <= !n_fault; // RULE11
		end
	end
	// open-drain: enable while pulling low
	assign fault_oe = !fault_n;
	assign overtemp_warning_oe = !overtemp_warning_n;
	assign power_fail_warning_oe = !power_fail_warning;

	// events: fault, thermal warning, power-fail, presence change
	logic prev_inst;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prev_inst <= 1'b0;
		else
			prev_inst <= inst_sync;
	end
	assign events = {prev_inst != inst_sync,
		!n_power_fail && power_fail_warning,
		!n_otw && overtemp_warning_n, !n_fault && fault_n};

	always_comb begin
		prdata = 32'h0;
		if (rd) begin
			unique case (paddr)
			`RALE_OFF_COND: prdata = 32'(c);
			`RALE_OFF_MODE: prdata = 32'(mode);
			`RALE_OFF_LAMP: prdata = {22'h0, !unit_inserted_flag,
				!power_fail_warning, !overtemp_warning_n, !fault_n,
				lamp_fault, lamp_service, lamp_output, lamp_input,
				l_red == RALE_LAMP_BLINK, l_svc == RALE_LAMP_BLINK};
			`RALE_OFF_STAT: prdata = 32'(status);
			`RALE_OFF_MASK: prdata = 32'(mask);
			default: prdata = 32'h0;
			endcase
		end
	end

	// ****************************************
	// checks
	// ****************************************
	// chk_quiet: no condition that ranks above service and comms in the priority chain is active
	logic chk_quiet;
	assign chk_quiet = in_ok && !ts && !shut_int && !tw && !ovc && !stby
		&& !intf;
	AST_RED_EXTERNAL: assert property ( // RULE11
		@(posedge pclk) disable iff (!presetn)
		in_present && !in_ok && !ts && !shut_int
		|=> !lamp_fault && fault_n)
		else $error("red lamp lit on external fault");
	AST_BUS_QUIET: assert property ( // RULE11
		@(posedge pclk) disable iff (!presetn)
		in_present && !in_ok && !ts && !shut_int |=> !bus_alarm)
		else $error("bus alarm raised on external fault");
	AST_PF_ABSENT: assert property ( // RULE7
		@(posedge pclk) disable iff (!presetn)
		!in_present |=> !power_fail_warning && !lamp_input)
		else $error("input absent not shown");
	AST_ABSENT_DARK: assert property ( // RULE7
		@(posedge pclk) disable iff (!presetn)
		!in_present |=> !lamp_output && !lamp_service && !lamp_fault
		&& fault_n && overtemp_warning_n)
		else $error("lamp or alarm active with input absent");
	AST_SHUT: assert property ( // RULE1
		@(posedge pclk) disable iff (!presetn)
		in_present && ts
		|=> !fault_n && !overtemp_warning_n && !power_fail_warning
		&& lamp_fault && lamp_service && !lamp_output)
		else $error("thermal shutdown not shown");
	AST_THERM_WARN: assert property ( // RULE1
		@(posedge pclk) disable iff (!presetn)
		in_ok && !ts && !shut_int && tw
		|=> !overtemp_warning_n && fault_n && lamp_service
		&& lamp_input && lamp_output && !lamp_fault)
		else $error("thermal warning not shown");
	AST_INTFAIL: assert property ( // RULE3
		@(posedge pclk) disable iff (!presetn)
		in_present && !ts && shut_int
		|=> !fault_n && !power_fail_warning && overtemp_warning_n
		&& lamp_input && lamp_fault && !lamp_output && !lamp_service)
		else $error("internal shutdown not shown");
	AST_OUT_LIMITS: assert property ( // RULE2
		@(posedge pclk) disable iff (!presetn)
		in_present && !in_ok && !ts && !shut_int
		|=> lamp_input == $past(blink) && !lamp_output && !lamp_service
		&& overtemp_warning_n)
		else $error("input out of limits not shown");
	AST_PRES: assert property ( // RULE10
		@(posedge pclk) disable iff (!presetn)
		$rose(inst_sync) |=> !unit_inserted_flag)
		else $error("presence flag wrong");
	AST_PRES_MISSING: assert property ( // RULE10
		@(posedge pclk) disable iff (!presetn)
		$fell(inst_sync) |=> unit_inserted_flag)
		else $error("missing unit not flagged");
	AST_BOOST: assert property ( // RULE8
		@(posedge pclk) disable iff (!presetn)
		boost_low |=> !power_fail_warning)
		else $error("power-fail missed boost decay");
	AST_NOTWARN: assert property ( // RULE4
		@(posedge pclk) disable iff (!presetn)
		in_ok && !ts && !shut_int && !tw && intf && !ovc && !stby
		|=> !fault_n && overtemp_warning_n && lamp_output && lamp_fault)
		else $error("non-shutdown fault wrong");
	AST_OVERCUR: assert property ( // RULE9
		@(posedge pclk) disable iff (!presetn)
		in_ok && !ts && !shut_int && !tw && ovc
		|=> lamp_output == $past(blink) && lamp_input
		&& !power_fail_warning && fault_n && !lamp_fault)
		else $error("over-current not shown");
	AST_STANDBY: assert property ( // RULE9
		@(posedge pclk) disable iff (!presetn)
		in_ok && !ts && !shut_int && !tw && !ovc && stby
		|=> !lamp_output && lamp_input && !power_fail_warning && fault_n)
		else $error("standby not shown");
	AST_SERVICE: assert property ( // RULE5
		@(posedge pclk) disable iff (!presetn)
		chk_quiet && svc
		|=> lamp_service == $past(blink) && lamp_output && !lamp_fault
		&& fault_n && overtemp_warning_n)
		else $error("service request not shown");
	AST_COMMS: assert property ( // RULE6
		@(posedge pclk) disable iff (!presetn)
		chk_quiet && !svc && comms
		|=> lamp_fault == $past(blink) && lamp_output && !lamp_service
		&& fault_n && overtemp_warning_n)
		else $error("comms fault not shown");
	AST_NORMAL: assert property ( // RULE10
		@(posedge pclk) disable iff (!presetn)
		chk_quiet && !svc && !comms && !boost_low
		|=> lamp_input && lamp_output && !lamp_service && !lamp_fault
		&& fault_n && overtemp_warning_n && power_fail_warning)
		else $error("normal state not shown");
	AST_IRQ: assert property ( // RULE4
		@(posedge pclk) disable iff (!presetn)
		$fell(fault_n) && mask[0] |-> irq)
		else $error("fault event lost");
	// a clear write must never swallow an event of the same cycle
	AST_SET_WINS: assert property (
		@(posedge pclk) disable iff (!presetn)
		events != '0 |=> (status & $past(events)) == $past(events))
		else $error("status event lost to clear");
endmodule

// ===== verilog/rale_pkg.sv
// types for the lamp and alarm encoder
// assumes nothing beyond a SystemVerilog compiler
package rale_pkg;
	typedef enum logic [1:0] {
		RALE_MODE_ANALOG = 2'b00,
		RALE_MODE_TWO_WIRE = 2'b01,
		RALE_MODE_SERIAL = 2'b10
	} rale_mode_type;
	typedef enum logic [1:0] {
		RALE_LAMP_OFF = 2'b00,
		RALE_LAMP_ON = 2'b01,
		RALE_LAMP_BLINK = 2'b10
	} rale_lamp_type;
endpackage
